// ===== artc_pkg.sv
// package: register map, field positions and divider counts of the timer
package artc_pkg;
    // ========================================================
    // register offsets
    localparam int unsigned ADDR_W = 8;
    localparam logic [7:0] OFS_CTRL = 8'h91;
    localparam logic [7:0] OFS_RLD_LO = 8'h92;
    localparam logic [7:0] OFS_RLD_HI = 8'h93;
    localparam logic [7:0] OFS_CNT_LO = 8'h94;
    localparam logic [7:0] OFS_CNT_HI = 8'h95;
    localparam logic [7:0] OFS_CLK_SEL = 8'h96;
    localparam logic [7:0] OFS_EVT_STAT = 8'h97;
    localparam logic [7:0] OFS_EVT_EN = 8'h98;
    localparam logic [7:0] OFS_EVT_CLR = 8'h99;

    // ========================================================
    // timer_control fields
    localparam int unsigned CTL_HOF = 7;
    localparam int unsigned CTL_LOF = 6;
    localparam int unsigned CTL_LIEN = 5;
    localparam int unsigned CTL_CEN = 4;
    localparam int unsigned CTL_SPLIT = 3;
    localparam int unsigned CTL_RUN = 2;
    localparam int unsigned CTL_CSRC = 1;
    localparam int unsigned CTL_XCLK = 0;

    // clock_select_register fields
    localparam int unsigned CKS_LO = 0;
    localparam int unsigned CKS_HI = 1;

    // event status / enable / clear fields
    localparam int unsigned EVT_W = 3;
    localparam int unsigned EVT_HOF = 0;
    localparam int unsigned EVT_LOF = 1;
    localparam int unsigned EVT_CAP = 2;

    // oscillator channels
    localparam int unsigned OSC_N = 2;
    localparam int unsigned OSC_EXT = 0;
    localparam int unsigned OSC_RTC = 1;

    // ========================================================
    // reset values and counts
    localparam logic [7:0] BYTE_RST = 8'h00;
    localparam logic [7:0] BYTE_MAX = 8'hff;
    localparam logic [1:0] CKS_RST = 2'h0;
    localparam logic [2:0] EVT_RST = 3'h0;
    localparam logic [3:0] SYS_DIV_LAST = 4'hb;
    localparam logic [2:0] OSC_DIV_LAST = 3'h7;
endpackage

// ===== artc_timer.sv
// auto-reload timer with split mode and oscillator capture
//
// Added by the designer: the strobed register port.
`timescale 1ns/100ps
// ============================================================
// Overview of operation
// - 16-bit mode: on 0xFFFF wrap load reload pair, set high flag.
// - 16-bit mode: full overflow requests interrupt when enabled.
// - 16-bit mode: low byte wrap also interrupts if low irq enabled.
// - split mode: two 8-bit timers, each reloads from its own byte.
// - split: run gates high byte only; 16-bit: run gates whole.
// - per-byte select: system clock, or div-12 / oscillator div-8.
// - oscillator div-8 source synchronised before counting.
// - high flag on high byte wrap; low flag on any low byte wrap.
// - split mode: high overflow interrupts; low too if enabled.
// - flags never cleared by hardware; software clears them.
// - capture enable gives capture every 8 oscillator cycles.
// - capture source: 0 rtc oscillator, 1 external oscillator.
// - capture copies count into reload pair and sets high flag.
// - alternate clock: 0 external div-8, 1 rtc div-8.
// - ext select 0 gives div-12; applies to both bytes.
// - count registers read/write the count bytes in both modes.
module artc_timer (
    input wire logic mclk_i,
    input wire logic rst_b_i,
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    input wire logic ext_osc_i,
    input wire logic rtc_osc_i,
    input wire logic tmr_irq_en_i,
    output logic tmr_irq_o,
    output logic evt_irq_o
);
    // ========================================================
    // registers and decode
    logic [7:0] ctrl;
    logic [7:0] rld_lo;
    logic [7:0] rld_hi;
    logic [7:0] cnt_lo;
    logic [7:0] cnt_hi;
    logic [1:0] clk_sel;
    logic [artc_pkg::EVT_W-1:0] evt_stat;
    logic [artc_pkg::EVT_W-1:0] evt_en;
    logic wr_ctrl;
    logic wr_rll;
    logic wr_rlh;
    logic wr_cl;
    logic wr_ch;

    assign wr_ctrl = wr_i && (addr_i == artc_pkg::OFS_CTRL);
    assign wr_rll = wr_i && (addr_i == artc_pkg::OFS_RLD_LO);
    assign wr_rlh = wr_i && (addr_i == artc_pkg::OFS_RLD_HI);
    assign wr_cl = wr_i && (addr_i == artc_pkg::OFS_CNT_LO);
    assign wr_ch = wr_i && (addr_i == artc_pkg::OFS_CNT_HI);

    // ========================================================
    // oscillator synchronisers and divide-by-8
    logic [artc_pkg::OSC_N-1:0] osc_raw;
    logic [artc_pkg::OSC_N-1:0] osc_tick;
    assign osc_raw[artc_pkg::OSC_EXT] = ext_osc_i;
    assign osc_raw[artc_pkg::OSC_RTC] = rtc_osc_i;
    genvar g;
    generate
        for (g = 0; g < artc_pkg::OSC_N; g++) begin : g_osc
            logic [2:0] sync;
            logic filt;
            logic rise;
            logic [2:0] div;
            logic tick;
            // three stages; a level counts once stages two and three agree
            always_ff @(posedge mclk_i) begin
                if (!rst_b_i) begin
                    sync <= 3'h0;
                end else begin
                    sync <= {sync[1:0], osc_raw[g]};
                end
            end
            assign rise = (sync[1] == sync[2]) && sync[2] && !filt;
            // filtered level, glitches shorter than a clock are dropped
            always_ff @(posedge mclk_i) begin
                if (!rst_b_i) begin
                    filt <= 1'b0;
                end else if (sync[1] == sync[2]) begin
                    filt <= sync[2];
                end
            end
            // eighth rising edge gives a one-cycle tick
            always_ff @(posedge mclk_i) begin
                if (!rst_b_i) begin
                    div <= 3'h0;
                    tick <= 1'b0;
                end else begin
                    tick <= rise && (div == artc_pkg::OSC_DIV_LAST);
                    if (rise) begin
                        div <= div + 3'h1;
                    end
                end
            end
            assign osc_tick[g] = tick;
        end
    endgenerate

    // ========================================================
    // system clock divide-by-12
    logic [3:0] pre;
    logic div12_tick;

    // free running, so the div-12 phase does not depend on run
    always_ff @(posedge mclk_i) begin
        if (!rst_b_i) begin
            pre <= 4'h0;
        end else if (pre == artc_pkg::SYS_DIV_LAST) begin
            pre <= 4'h0;
        end else begin
            pre <= pre + 4'h1;
        end
    end

    assign div12_tick = (pre == artc_pkg::SYS_DIV_LAST);

    // ========================================================
    // count clock selection
    logic alt_tick;
    logic lo_tick;
    logic hi_tick;
    logic cap_evt;
    logic ext_tick;
    logic rtc_tick;

    assign ext_tick = osc_tick[artc_pkg::OSC_EXT];
    assign rtc_tick = osc_tick[artc_pkg::OSC_RTC];

    // alternate clock shared by both bytes
    assign alt_tick = !ctrl[artc_pkg::CTL_XCLK] ? div12_tick :
        (ctrl[artc_pkg::CTL_CSRC] ? rtc_tick : ext_tick);
    assign lo_tick = clk_sel[artc_pkg::CKS_LO] ? 1'b1 : alt_tick;
    assign hi_tick = clk_sel[artc_pkg::CKS_HI] ? 1'b1 : alt_tick;

    // capture trigger source
    assign cap_evt = ctrl[artc_pkg::CTL_CEN] &&
        (ctrl[artc_pkg::CTL_CSRC] ? ext_tick : rtc_tick);

    // ========================================================
    // next count and wrap events
    logic [7:0] next_cnt_lo;
    logic [7:0] next_cnt_hi;
    logic lo_wrap;
    logic hi_wrap;

    always_comb begin
        next_cnt_lo = cnt_lo;
        next_cnt_hi = cnt_hi;
        lo_wrap = 1'b0;
        hi_wrap = 1'b0;
        if (!ctrl[artc_pkg::CTL_SPLIT]) begin
            // 16-bit mode uses the low byte's clock select
            if (ctrl[artc_pkg::CTL_RUN] && lo_tick) begin
                lo_wrap = (cnt_lo == artc_pkg::BYTE_MAX);
                if (lo_wrap && cnt_hi == artc_pkg::BYTE_MAX) begin
                    next_cnt_lo = rld_lo;
                    next_cnt_hi = rld_hi;
                    hi_wrap = 1'b1;
                end else begin
                    {next_cnt_hi, next_cnt_lo} = {cnt_hi, cnt_lo} + 16'h1;
                end
            end
        end else begin
            // low byte ignores run in split mode
            if (lo_tick) begin
                if (cnt_lo == artc_pkg::BYTE_MAX) begin
                    next_cnt_lo = rld_lo;
                    lo_wrap = 1'b1;
                end else begin
                    next_cnt_lo = cnt_lo + 8'h1;
                end
            end
            if (ctrl[artc_pkg::CTL_RUN] && hi_tick) begin
                if (cnt_hi == artc_pkg::BYTE_MAX) begin
                    next_cnt_hi = rld_hi;
                    hi_wrap = 1'b1;
                end else begin
                    next_cnt_hi = cnt_hi + 8'h1;
                end
            end
        end
    end

    // counter bytes; a software write beats the count in that cycle
    always_ff @(posedge mclk_i) begin
        if (!rst_b_i) begin
            cnt_lo <= artc_pkg::BYTE_RST;
            cnt_hi <= artc_pkg::BYTE_RST;
        end else begin
            cnt_lo <= wr_cl ? wdata_i : next_cnt_lo;
            cnt_hi <= wr_ch ? wdata_i : next_cnt_hi;
        end
    end

    // reload pair; capture beats a software write
    always_ff @(posedge mclk_i) begin
        if (!rst_b_i) begin
            rld_lo <= artc_pkg::BYTE_RST;
            rld_hi <= artc_pkg::BYTE_RST;
        end else if (cap_evt) begin
            rld_lo <= cnt_lo;
            rld_hi <= cnt_hi;
        end else begin
            if (wr_rll) begin
                rld_lo <= wdata_i;
            end
            if (wr_rlh) begin
                rld_hi <= wdata_i;
            end
        end
    end

    // control; hardware only ever sets the flags, and set wins
    always_ff @(posedge mclk_i) begin
        if (!rst_b_i) begin
            ctrl <= artc_pkg::BYTE_RST;
        end else begin
            if (wr_ctrl) begin
                ctrl <= wdata_i;
            end
            if (hi_wrap || cap_evt) begin
                ctrl[artc_pkg::CTL_HOF] <= 1'b1;
            end
            if (lo_wrap) begin
                ctrl[artc_pkg::CTL_LOF] <= 1'b1;
            end
        end
    end

    // per-byte clock selects
    always_ff @(posedge mclk_i) begin
        if (!rst_b_i) begin
            clk_sel <= artc_pkg::CKS_RST;
        end else if (wr_i && addr_i == artc_pkg::OFS_CLK_SEL) begin
            clk_sel <= wdata_i[1:0];
        end
    end

    // ========================================================
    // timer interrupt request toward the interrupt system
    always_ff @(posedge mclk_i) begin
        if (!rst_b_i) begin
            tmr_irq_o <= 1'b0;
        end else begin
            tmr_irq_o <= tmr_irq_en_i &&
                (ctrl[artc_pkg::CTL_HOF] ||
                (ctrl[artc_pkg::CTL_LIEN] && ctrl[artc_pkg::CTL_LOF]));
        end
    end

    // ========================================================
    // event status, enable and write-one-to-clear
    logic [artc_pkg::EVT_W-1:0] evt_set;
    logic [artc_pkg::EVT_W-1:0] evt_clr;

    assign evt_set = {cap_evt, lo_wrap, hi_wrap};
    assign evt_clr = (wr_i && addr_i == artc_pkg::OFS_EVT_CLR) ?
        wdata_i[artc_pkg::EVT_W-1:0] : artc_pkg::EVT_RST;

    // set wins over a clear in the same cycle
    always_ff @(posedge mclk_i) begin
        if (!rst_b_i) begin
            evt_stat <= artc_pkg::EVT_RST;
        end else begin
            evt_stat <= (evt_stat & ~evt_clr) | evt_set;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_b_i) begin
            evt_en <= artc_pkg::EVT_RST;
        end else if (wr_i && addr_i == artc_pkg::OFS_EVT_EN) begin
            evt_en <= wdata_i[artc_pkg::EVT_W-1:0];
        end
    end

    // one cycle behind the status bits, to keep the output a flop
    always_ff @(posedge mclk_i) begin
        if (!rst_b_i) begin
            evt_irq_o <= 1'b0;
        end else begin
            evt_irq_o <= |(evt_stat & evt_en);
        end
    end

    // ========================================================
    // read port, data valid the cycle after the strobe only
    logic [7:0] rd_mux;

    always_comb begin
        unique case (addr_i)
            artc_pkg::OFS_CTRL: rd_mux = ctrl;
            artc_pkg::OFS_RLD_LO: rd_mux = rld_lo;
            artc_pkg::OFS_RLD_HI: rd_mux = rld_hi;
            artc_pkg::OFS_CNT_LO: rd_mux = cnt_lo;
            artc_pkg::OFS_CNT_HI: rd_mux = cnt_hi;
            artc_pkg::OFS_CLK_SEL: rd_mux = {6'h0, clk_sel};
            artc_pkg::OFS_EVT_STAT: rd_mux = {5'h0, evt_stat};
            artc_pkg::OFS_EVT_EN: rd_mux = {5'h0, evt_en};
            default: rd_mux = 8'h00;
        endcase
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_b_i) begin
            rdata_o <= 8'h00;
        end else begin
            rdata_o <= rd_i ? rd_mux : 8'h00;
        end
    end

    // ========================================================
    // assertions
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_b_i);

    chk_full_reload: assert property (
        !ctrl[artc_pkg::CTL_SPLIT] && ctrl[artc_pkg::CTL_RUN] && lo_tick &&
        {cnt_hi, cnt_lo} == 16'hffff && !wr_cl && !wr_ch
        |=> {cnt_hi, cnt_lo} == $past({rld_hi, rld_lo}) &&
            ctrl[artc_pkg::CTL_HOF])
        else $error("16-bit overflow did not reload");
    chk_full_irq: assert property (
        tmr_irq_en_i && ctrl[artc_pkg::CTL_HOF] |=> tmr_irq_o)
        else $error("high flag did not raise request");
    chk_low_irq: assert property (
        tmr_irq_en_i && ctrl[artc_pkg::CTL_LIEN] && ctrl[artc_pkg::CTL_LOF]
        |=> tmr_irq_o)
        else $error("low flag did not raise request");
    chk_split_lo_reload: assert property (
        ctrl[artc_pkg::CTL_SPLIT] && lo_tick && cnt_lo == 8'hff && !wr_cl
        |=> cnt_lo == $past(rld_lo) && ctrl[artc_pkg::CTL_LOF])
        else $error("split low byte did not reload");
    chk_run_stop: assert property (
        !ctrl[artc_pkg::CTL_RUN] && !wr_ch |=> $stable(cnt_hi))
        else $error("high byte moved while stopped");
    chk_split_lo_free: assert property (
        ctrl[artc_pkg::CTL_SPLIT] && lo_tick && cnt_lo != 8'hff && !wr_cl
        |=> cnt_lo == $past(cnt_lo) + 8'h1)
        else $error("split low byte did not count");
    chk_div12_period: assert property (
        div12_tick |=> !div12_tick [*8] ##1 !div12_tick [*3] ##1 div12_tick)
        else $error("div-12 tick spacing wrong");
    chk_osc_pulse: assert property (
        ext_tick |=> !ext_tick [*8])
        else $error("external div-8 tick too frequent");
    chk_flag_sticky: assert property (
        ctrl[artc_pkg::CTL_HOF] && !wr_ctrl |=> ctrl[artc_pkg::CTL_HOF])
        else $error("high flag cleared by hardware");
    chk_capture_copy: assert property (
        cap_evt |=> {rld_hi, rld_lo} == $past({cnt_hi, cnt_lo}) &&
            ctrl[artc_pkg::CTL_HOF] && evt_stat[artc_pkg::EVT_CAP])
        else $error("capture did not copy count");
    cov_full_ovf: cover property (
        !ctrl[artc_pkg::CTL_SPLIT] && hi_wrap);
    cov_split_both: cover property (
        ctrl[artc_pkg::CTL_SPLIT] && lo_wrap ##[1:300] hi_wrap);
    cov_capture: cover property (cap_evt ##[1:1000] cap_evt);
endmodule

// ===== tb.sv
// testbench: registers, overflow, split mode, clock sources and capture
`timescale 1ns/100ps
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin fails++; \
    $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); end end
module tb;
    logic mclk_i;
    logic rst_b_i;
    logic wr_i;
    logic rd_i;
    logic [7:0] addr_i;
    logic [7:0] wdata_i;
    logic [7:0] rdata_o;
    logic ext_osc_i;
    logic rtc_osc_i;
    logic tmr_irq_en_i;
    logic tmr_irq_o;
    logic evt_irq_o;
    logic [7:0] d;
    logic [3:0] osc_cnt;
    int fails;
    int checks;

    artc_timer uut (
        .mclk_i(mclk_i),
        .rst_b_i(rst_b_i),
        .addr_i(addr_i),
        .wdata_i(wdata_i),
        .wr_i(wr_i),
        .rd_i(rd_i),
        .rdata_o(rdata_o),
        .ext_osc_i(ext_osc_i),
        .rtc_osc_i(rtc_osc_i),
        .tmr_irq_en_i(tmr_irq_en_i),
        .tmr_irq_o(tmr_irq_o),
        .evt_irq_o(evt_irq_o)
    );

    // 10 MHz system clock
    initial begin
        mclk_i = 1'b0;
        forever #50 mclk_i = ~mclk_i;
    end

    // oscillators: rtc period 8 clocks, external period 16 clocks, so the
    // two capture sources give different deltas and a wrong pick shows
    always @(posedge mclk_i) begin
        osc_cnt <= osc_cnt + 4'h1;
        if (osc_cnt[1:0] == 2'h3) rtc_osc_i <= ~rtc_osc_i;
        if (osc_cnt[2:0] == 3'h7) ext_osc_i <= ~ext_osc_i;
    end

    // ========================================================
    // bus and helper tasks
    // gap cycle after each strobe so no signal is assigned twice at an edge
    task automatic wr(input logic [7:0] ad, input logic [7:0] dt);
        wr_i <= 1'b1;
        addr_i <= ad;
        wdata_i <= dt;
        @(posedge mclk_i);
        wr_i <= 1'b0;
        @(posedge mclk_i);
    endtask

    task automatic rd(input logic [7:0] ad, output logic [7:0] dt);
        rd_i <= 1'b1;
        addr_i <= ad;
        @(posedge mclk_i);
        rd_i <= 1'b0;
        #1 dt = rdata_o;
        @(posedge mclk_i);
    endtask

    task automatic chk_rd(input string nm, input logic [7:0] ad,
                          input logic [7:0] e);
        rd(ad, d);
        `CHK(nm, e, d)
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge mclk_i);
    endtask

    // bounded wait for one of the two interrupt outputs
    task automatic wait_sig(input int sel, input int n);
        int i;
        for (i = 0; i < n; i++) begin
            @(posedge mclk_i);
            #1;
            if ((sel == 0 ? tmr_irq_o : evt_irq_o) === 1'b1) break;
        end
        if (i == n) begin
            fails++;
            $display("CHECK FAILED wait_irq exp 1 got 0");
            wrap_up();
        end
    endtask

    task automatic wrap_up();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    // ========================================================
    // scenarios
    task automatic s_regs();
        int k;
        for (k = 0; k < 9; k++) chk_rd("rst", 8'h91 + k[7:0], 8'h00);
        chk_rd("unmapped", 8'ha0, 8'h00);
        for (k = 0; k < 4; k++) wr(8'h92 + k[7:0], {k[3:0], 4'ha});
        for (k = 0; k < 4; k++) begin
            chk_rd("rw", 8'h92 + k[7:0], {k[3:0], 4'ha});
        end
        wr(8'h97, 8'hff);
        wr(8'h99, 8'hff);
        chk_rd("stat_ro", 8'h97, 8'h00);
        chk_rd("clr_wo", 8'h99, 8'h00);
    endtask

    // 16-bit wrap reloads, flags stick, event status and mask
    task automatic s_ovf16();
        tmr_irq_en_i <= 1'b1;
        wr(8'h98, 8'h01);
        wr(8'h96, 8'h01);
        wr(8'h92, 8'h34);
        wr(8'h93, 8'h12);
        wr(8'h94, 8'hf0);
        wr(8'h95, 8'hff);
        wr(8'h91, 8'h04);
        `CHK("irq_early", 1'b0, tmr_irq_o)
        wait_sig(0, 40);
        wait_sig(1, 5);
        idle(20);
        chk_rd("ctrl", 8'h91, 8'hc4);
        chk_rd("cnt_hi", 8'h95, 8'h12);
        chk_rd("stat", 8'h97, 8'h03);
        wr(8'h99, 8'h01);
        chk_rd("stat_clr", 8'h97, 8'h02);
        `CHK("evt_masked", 1'b0, evt_irq_o)
        wr(8'h98, 8'h02);
        idle(2);
        `CHK("evt_on", 1'b1, evt_irq_o)
        wr(8'h99, 8'h02);
        wr(8'h98, 8'h00);
        wr(8'h91, 8'h00);
        idle(2);
        `CHK("irq_clr", 1'b0, tmr_irq_o)
    endtask

    // low byte wrap in 16-bit mode interrupts only with low enable
    task automatic s_lowirq();
        wr(8'h94, 8'hf0);
        wr(8'h95, 8'h10);
        wr(8'h91, 8'h04);
        idle(30);
        `CHK("lo_noirq", 1'b0, tmr_irq_o)
        chk_rd("lof_only", 8'h91, 8'h44);
        wr(8'h91, 8'h60);
        idle(2);
        `CHK("lo_irq", 1'b1, tmr_irq_o)
        tmr_irq_en_i <= 1'b0;
        idle(2);
        `CHK("irq_gated", 1'b0, tmr_irq_o)
        tmr_irq_en_i <= 1'b1;
        wr(8'h91, 8'h00);
    endtask

    // split: low byte free running, high byte held until run set
    task automatic s_split();
        wr(8'h96, 8'h03);
        wr(8'h92, 8'hf0);
        wr(8'h93, 8'h80);
        wr(8'h94, 8'hfe);
        wr(8'h95, 8'hfe);
        wr(8'h91, 8'h08);
        idle(30);
        chk_rd("hi_held", 8'h95, 8'hfe);
        chk_rd("split_fl", 8'h91, 8'h48);
        `CHK("split_noirq", 1'b0, tmr_irq_o)
        rd(8'h94, d);
        `CHK("lo_reload", 4'hf, d[7:4])
        wr(8'h91, 8'h0c);
        wait_sig(0, 10);
        rd(8'h95, d);
        `CHK("hi_reload", 4'h8, d[7:4])
        wr(8'h91, 8'h00);
    endtask

    // alternate clock: div-12, external div-8, rtc div-8 over 512 clocks
    task automatic s_alt();
        int k;
        logic ok;
        logic [7:0] ctl[3] = '{8'h04, 8'h05, 8'h07};
        int ex[3] = '{43, 4, 8};
        wr(8'h96, 8'h00);
        for (k = 0; k < 3; k++) begin
            wr(8'h94, 8'h00);
            wr(8'h95, 8'h00);
            wr(8'h91, ctl[k]);
            idle(512);
            rd(8'h94, d);
            ok = (d >= ex[k] - 1) && (d <= ex[k] + 1);
            `CHK("alt_cnt", 1'b1, ok)
            // stop before the count bytes are cleared, so the old source
            // cannot tick in between and skew the next sample
            wr(8'h91, 8'h00);
        end
    endtask

    // capture delta equals 8 periods of the selected oscillator
    task automatic s_capture();
        int k;
        logic [15:0] a0;
        logic [15:0] a1;
        logic [15:0] ex;
        logic [7:0] c;
        wr(8'h96, 8'h01);
        for (k = 0; k < 2; k++) begin
            c = (k == 0) ? 8'h14 : 8'h16;
            ex = (k == 0) ? 16'h0040 : 16'h0080;
            wr(8'h91, c);
            wait_sig(0, 300);
            rd(8'h92, a0[7:0]);
            rd(8'h93, a0[15:8]);
            wr(8'h91, c);
            wait_sig(0, 300);
            rd(8'h92, a1[7:0]);
            rd(8'h93, a1[15:8]);
            a1 = a1 - a0;
            `CHK("cap_delta", ex, a1)
        end
        wr(8'h91, 8'h00);
        chk_rd("cap_stat", 8'h97, 8'h07);
    endtask

    // ========================================================
    // main sequence
    initial begin
        rst_b_i = 1'b0;
        wr_i = 1'b0;
        rd_i = 1'b0;
        addr_i = 8'h00;
        wdata_i = 8'h00;
        ext_osc_i = 1'b0;
        rtc_osc_i = 1'b0;
        tmr_irq_en_i = 1'b0;
        osc_cnt = 4'h0;
        fails = 0;
        checks = 0;
        repeat (4) @(posedge mclk_i);
        rst_b_i <= 1'b1;
        @(posedge mclk_i);
        s_regs();
        s_ovf16();
        s_lowirq();
        s_split();
        s_alt();
        s_capture();
        wrap_up();
    end
endmodule
